// >>> hdl/sesl_logs.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R01] error log version byte reads 01h
// [R02] error index names newest, zero when empty
// [R03] error log spans two supported sectors
// [R04] full log overwrites oldest structure in order
// [R05] unused error structures read all zero
// [R06] five 90-byte structures per sector from byte 2
// [R07] device error count saturates at maximum
// [R08] self-test revision bytes read 0001h
// [R09] 21 circular 24-byte descriptors from byte 2
// [R10] unused descriptors read all zero
// [R11] descriptor field layout, low byte first
// [R12] failing LBA kept only for uncorrectable failures
// [R13] self-test index zero empty, wraps to one
// [R14] byte 511 makes sector sum zero
// [R15] selective revision returned as written
// [R16] spans stored and returned unchanged
// [R17] current LBA is block start, zero when done
// [R18] span number, above five in scan, zero done
// [R19] scan request kept, pending/active device owned; host writes to flags byte 502 also set them here
// [R20] host zeroes progress fields before a test
// [R21] pending timer expiry sets active, resumes scan
// [R22] checksums follow every device change
module sesl_logs #(
  parameter longint MINUTE_CYCLES = sesl_pkg::MINUTE_CYCLES
) (
  // clock and reset
  input  wire  logic                        clock,
  input  wire  logic                        rst,
  // log access port
  input  wire  logic [sesl_pkg::ADDR_W-1:0] addr,
  input  wire  logic [7:0]                  wdata,
  input  wire  logic                        wr,
  input  wire  logic                        rd,
  output logic       [7:0]                  rdata,
  // error events
  input  wire  logic                        err_log,
  input  wire  logic                        err_dev,
  input  wire  logic [63:0]                 err_record,
  // self-test completion
  input  wire  logic                        st_log,
  input  wire  logic [7:0]                  st_sector,
  input  wire  logic [7:0]                  st_status,
  input  wire  logic [15:0]                 st_hours,
  input  wire  logic [7:0]                  st_checkpoint,
  input  wire  logic                        st_fail_unc,
  input  wire  logic [31:0]                 st_fail_lba,
  // selective test progress
  input  wire  logic                        sel_prog,
  input  wire  logic [63:0]                 sel_prog_lba,
  input  wire  logic [15:0]                 sel_prog_span,
  input  wire  logic                        sel_done,
  input  wire  logic                        scan_suspend,
  input  wire  logic                        scan_finish,
  // scan control out
  output logic                              scan_req,
  output logic                              scan_resume
);
  import sesl_pkg::*;

  localparam logic [TMR_W-1:0] MIN_LAST = TMR_W'(MINUTE_CYCLES - 1);

  // sum of the low n bytes of a record, modulo 256
  function automatic logic [7:0] bsum(input logic [71:0] v, input int n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        s = s + v[8*i +: 8];
      end
    end
    return s;
  endfunction : bsum

  // stored state
  logic [63:0] err_rec_q [ERR_SLOTS];
  logic [3:0]  err_wp_q;
  logic [7:0]  err_idx_q;
  logic [15:0] err_cnt_q;
  logic [71:0] st_rec_q [ST_SLOTS];
  logic [4:0]  st_wp_q;
  logic [7:0]  st_idx_q;
  logic [7:0]  sel_mem_q [SEL_HOST_BYTES];
  logic [63:0] cur_lba_q, cur_lba_d;
  logic [15:0] cur_span_q, cur_span_d;
  logic [15:0] flags_q, flags_d;
  logic [15:0] pend_q, pend_d;
  logic [TMR_W-1:0] tick_q;
  logic [15:0] elapsed_q;
  logic        armed_q;
  logic [7:0]  rdata_q;
  logic        resume_q;

  // address fields
  wire [1:0] a_log = addr[A_LOG_HI:A_LOG_LO];
  wire [5:0] a_sec = addr[A_SEC_HI:A_SEC_LO];
  wire [8:0] a_b   = addr[A_BYTE_HI:0];

  // error log byte decode: slot = 5*sector + (b-2)/90
  wire [8:0] e_rel  = a_b - B_ERR_FIRST;
  wire [2:0] e_k    = 3'(e_rel / ERR_STRUCT);                      // [R06]
  wire [6:0] e_off  = 7'(e_rel % ERR_STRUCT);
  wire [3:0] e_slot = a_sec[0] ? 4'(e_k) + ERR_PER_SECT : 4'(e_k);
  wire       e_sec_ok = a_sec < ERR_SECTORS;                         // [R03]
  wire       e_in   = a_b >= B_ERR_FIRST && a_b <= B_ERR_LAST;
  wire [7:0] e_rec  = err_rec_q[e_slot][8*e_off[2:0] +: 8];
  wire [7:0] e_str  = (e_off < 7'(ERR_REC_BYTES)) ? e_rec : 8'h00;   // [R05]

  // self-test byte decode: slot = (b-2)/24
  wire [8:0] s_rel  = a_b - B_ST_FIRST;
  wire [4:0] s_k    = 5'(s_rel / ST_DESC);                           // [R09]
  wire [4:0] s_off  = 5'(s_rel % ST_DESC);
  wire       s_in   = a_b >= B_ST_FIRST && a_b <= B_ST_LAST;
  wire [7:0] s_rec  = st_rec_q[s_k][8*s_off[3:0] +: 8];
  wire [7:0] s_desc = (s_off < 5'(ST_REC_BYTES)) ? s_rec : 8'h00;    // [R10]

  // per-sector checksums, always current with the stored state
  logic [7:0] err_sum [2];
  logic [7:0] st_sum, sel_sum;
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_err_sum
      always_comb begin
        err_sum[gs] = 8'h00;
        for (int j = 0; j < 5; j++) begin
          err_sum[gs] = err_sum[gs]
                        + bsum({8'h00, err_rec_q[gs*5+j]}, ERR_REC_BYTES);
        end
        if (gs == 0) begin
          err_sum[gs] = err_sum[gs] + ERR_VERSION + err_idx_q
                        + err_cnt_q[7:0] + err_cnt_q[15:8];
        end
      end
    end
  endgenerate

  // self-test and selective sums
  always_comb begin
    st_sum = ST_REV_LO + ST_REV_HI + st_idx_q;
    for (int j = 0; j < ST_SLOTS; j++) begin
      st_sum = st_sum + bsum(st_rec_q[j], ST_REC_BYTES);
    end
    sel_sum = bsum({8'h00, cur_lba_q}, 8)
              + cur_span_q[7:0] + cur_span_q[15:8]
              + flags_q[7:0] + flags_q[15:8]
              + pend_q[7:0] + pend_q[15:8];
    for (int j = 0; j < SEL_HOST_BYTES; j++) begin
      sel_sum = sel_sum + sel_mem_q[j];
    end
  end

  wire [7:0] err_chk = 8'h00 - err_sum[a_sec[0]];                    // [R14]
  wire [7:0] st_chk  = 8'h00 - st_sum;                               // [R14]
  wire [7:0] sel_chk = 8'h00 - sel_sum;                              // [R22]

  // error log read byte; later sectors hold only structures
  wire       e_hdr = a_sec == 6'h00;
  wire [7:0] err_byte =
    !e_sec_ok                 ? 8'h00 :
    (a_b == B_CHK)            ? err_chk :
    e_in                      ? e_str :
    (e_hdr && a_b == 9'h000)  ? ERR_VERSION :                        // [R01]
    (e_hdr && a_b == 9'h001)  ? err_idx_q :
    (e_hdr && a_b == B_CNT_LO) ? err_cnt_q[7:0] :
    (e_hdr && a_b == B_CNT_HI) ? err_cnt_q[15:8] : 8'h00;

  // self-test read byte
  wire       s_hdr = a_sec == 6'h00;
  wire [7:0] st_byte =
    !s_hdr                    ? 8'h00 :
    (a_b == 9'h000)           ? ST_REV_LO :                          // [R08]
    (a_b == 9'h001)           ? ST_REV_HI :
    s_in                      ? s_desc :
    (a_b == B_ST_IDX)         ? st_idx_q :
    (a_b == B_CHK)            ? st_chk : 8'h00;

  // selective log read byte
  wire [2:0] lba_i = 3'(a_b - B_LBA_FIRST);
  wire       in_lba = a_b >= B_LBA_FIRST && a_b <= B_LBA_LAST;
  wire [7:0] sel_byte =
    !s_hdr                    ? 8'h00 :
    (a_b <= B_SEL_LAST)       ? sel_mem_q[a_b[6:0]] :                // [R16]
    in_lba                    ? cur_lba_q[8*lba_i +: 8] :
    (a_b == B_SPAN_LO)        ? cur_span_q[7:0] :
    (a_b == B_SPAN_HI)        ? cur_span_q[15:8] :
    (a_b == B_FLG_LO)         ? flags_q[7:0] :
    (a_b == B_FLG_HI)         ? flags_q[15:8] :
    (a_b == B_PEND_LO)        ? pend_q[7:0] :
    (a_b == B_PEND_HI)        ? pend_q[15:8] :
    (a_b == B_CHK)            ? sel_chk : 8'h00;

  wire [7:0] rd_byte = (a_log == LOG_ERR) ? err_byte :
                       (a_log == LOG_ST)  ? st_byte  :
                       (a_log == LOG_SEL) ? sel_byte : 8'h00;

  // host writes reach only the selective log
  wire wr_sel = wr && a_log == LOG_SEL && s_hdr;
  wire expire = armed_q && flags_q[FLAG_PEND] && elapsed_q >= pend_q;

  // selective progress fields: device updates win over host bytes
  always_comb begin
    cur_lba_d  = cur_lba_q;
    cur_span_d = cur_span_q;
    if (wr_sel && in_lba) begin
      cur_lba_d[8*lba_i +: 8] = wdata;                               // [R20]
    end
    if (wr_sel && a_b == B_SPAN_LO) begin
      cur_span_d[7:0] = wdata;
    end
    if (wr_sel && a_b == B_SPAN_HI) begin
      cur_span_d[15:8] = wdata;
    end
    if (sel_prog) begin
      cur_lba_d  = sel_prog_lba & LBA_BLOCK_MASK;                    // [R17]
      cur_span_d = sel_prog_span;                                    // [R18]
    end
    if (expire) begin
      cur_span_d = SPAN_SCAN;                                        // [R18]
    end
    if (sel_done) begin
      cur_lba_d  = 64'h0000_0000_0000_0000;                          // [R17]
      cur_span_d = 16'h0000;                                         // [R18]
    end
  end

  // feature flags and pending time
  always_comb begin
    flags_d = flags_q;
    pend_d  = pend_q;
    if (wr_sel && a_b == B_FLG_LO) begin
      flags_d[7:0] = wdata;                                          // [R19]
    end
    if (wr_sel && a_b == B_FLG_HI) begin
      flags_d[15:8] = wdata;
    end
    if (wr_sel && a_b == B_PEND_LO) begin
      pend_d[7:0] = wdata;
    end
    if (wr_sel && a_b == B_PEND_HI) begin
      pend_d[15:8] = wdata;
    end
    if (scan_suspend) begin
      flags_d[FLAG_PEND] = 1'b1;                                     // [R19]
      flags_d[FLAG_ACT]  = 1'b0;
    end
    if (scan_finish) begin
      flags_d[FLAG_PEND] = 1'b0;                                     // [R19]
      flags_d[FLAG_ACT]  = 1'b0;
    end
    if (expire) begin
      flags_d[FLAG_PEND] = 1'b0;                                     // [R21]
      flags_d[FLAG_ACT]  = 1'b1;
    end
  end

  // comprehensive error log: circular slots, index, saturating count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ERR_SLOTS; i++) err_rec_q[i] <= '0;
      err_wp_q  <= 4'h0;
      err_idx_q <= 8'h00;
      err_cnt_q <= 16'h0000;
    end else begin
      if (err_log) begin
        err_rec_q[err_wp_q] <= err_record;                           // [R04]
        err_wp_q  <= (err_wp_q == ERR_LAST_SLOT) ? 4'h0 : err_wp_q + 4'h1;
        err_idx_q <= {4'h0, err_wp_q} + 8'h01;                       // [R02]
      end
      if (err_log && err_dev && err_cnt_q != CNT_MAX) begin
        err_cnt_q <= err_cnt_q + 16'h0001;                           // [R07]
      end
    end
  end

  // self-test log: 21 circular descriptors
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ST_SLOTS; i++) st_rec_q[i] <= '0;
      st_wp_q  <= 5'h00;
      st_idx_q <= 8'h00;
    end else if (st_log) begin
      st_rec_q[st_wp_q] <= {st_fail_unc ? st_fail_lba : 32'h0000_0000, // [R12]
                            st_checkpoint, st_hours, st_status,
                            st_sector};                              // [R11]
      st_wp_q  <= (st_wp_q == ST_LAST_SLOT) ? 5'h00 : st_wp_q + 5'h01; // [R09]
      st_idx_q <= {3'h0, st_wp_q} + 8'h01;                           // [R13]
    end
  end

  // selective log storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SEL_HOST_BYTES; i++) sel_mem_q[i] <= 8'h00;
      cur_lba_q  <= 64'h0000_0000_0000_0000;
      cur_span_q <= 16'h0000;
      flags_q    <= 16'h0000;
      pend_q     <= 16'h0000;
    end else begin
      if (wr_sel && a_b <= B_SEL_LAST) begin
        sel_mem_q[a_b[6:0]] <= wdata;                                // [R15]
      end
      cur_lba_q  <= cur_lba_d;
      cur_span_q <= cur_span_d;
      flags_q    <= flags_d;
      pend_q     <= pend_d;
    end
  end

  // minutes since power-on; armed once per reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_q    <= '0;
      elapsed_q <= 16'h0000;
      armed_q   <= 1'b1;
      resume_q  <= 1'b0;
    end else begin
      tick_q <= (tick_q == MIN_LAST) ? '0 : tick_q + 1'b1;
      if (tick_q == MIN_LAST && elapsed_q != CNT_MAX) begin
        elapsed_q <= elapsed_q + 16'h0001;                           // [R21]
      end
      if (expire) begin
        armed_q <= 1'b0;
      end
      resume_q <= expire;                                            // [R21]
    end
  end

  // read data register, valid the cycle after rd
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rd_byte : 8'h00;
    end
  end

  assign rdata       = rdata_q;
  assign scan_resume = resume_q;
  assign scan_req    = flags_q[FLAG_SCAN_REQ];                       // [R19]

  // checks
  property p_err_version;
    @(posedge clock) disable iff (rst)
    rd && a_log == LOG_ERR && a_sec == 6'h00 && a_b == 9'h000
      |=> rdata == ERR_VERSION;
  endproperty
  a_err_version: assert property (p_err_version) // [R01]
    else $error("error log version not 01h");

  property p_err_idx;
    @(posedge clock) disable iff (rst)
    err_log |=> err_idx_q == {4'h0, $past(err_wp_q)} + 8'h01
                && err_idx_q <= 8'(ERR_SLOTS);
  endproperty
  a_err_idx: assert property (p_err_idx) // [R02]
    else $error("error index not newest structure");

  property p_err_wrap;
    @(posedge clock) disable iff (rst)
    err_log && err_wp_q == ERR_LAST_SLOT |=> err_wp_q == 4'h0;
  endproperty
  a_err_wrap: assert property (p_err_wrap) // [R04]
    else $error("error log did not wrap to oldest");

  property p_cnt_sat;
    @(posedge clock) disable iff (rst)
    err_log && err_dev |=> err_cnt_q == (($past(err_cnt_q) == CNT_MAX)
      ? CNT_MAX : $past(err_cnt_q) + 16'h0001);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) // [R07]
    else $error("device error count wrapped");

  property p_st_idx;
    @(posedge clock) disable iff (rst)
    st_log && st_idx_q == 8'(ST_SLOTS) |=> st_idx_q == 8'h01;
  endproperty
  a_st_idx: assert property (p_st_idx) // [R13]
    else $error("self-test index did not return to one");

  property p_sel_rev;
    @(posedge clock) disable iff (rst)
    wr_sel && a_b == 9'h000 |=> sel_mem_q[0] == $past(wdata);
  endproperty
  a_sel_rev: assert property (p_sel_rev) // [R15]
    else $error("selective revision not kept");

  property p_lba_block;
    @(posedge clock) disable iff (rst)
    sel_prog && !sel_done |=> cur_lba_q[15:0] == 16'h0000
      && cur_lba_q[63:16] == $past(sel_prog_lba[63:16]);
  endproperty
  a_lba_block: assert property (p_lba_block) // [R17]
    else $error("current lba not block start");

  property p_done_zero;
    @(posedge clock) disable iff (rst)
    sel_done |=> cur_lba_q == 64'h0000_0000_0000_0000
      && cur_span_q == 16'h0000;
  endproperty
  a_done_zero: assert property (p_done_zero) // [R18]
    else $error("progress fields not cleared at done");

  property p_expire;
    @(posedge clock) disable iff (rst)
    expire && !scan_finish && !scan_suspend |=> flags_q[FLAG_ACT]
      && !flags_q[FLAG_PEND] && scan_resume && !armed_q;
  endproperty
  a_expire: assert property (p_expire) // [R21]
    else $error("pending expiry did not start scan");

endmodule : sesl_logs

`default_nettype wire

// >>> shared/sesl_pkg.sv
package sesl_pkg;

  // address fields of the log port: log select, sector, byte
  localparam int ADDR_W    = 17;
  localparam int A_LOG_HI  = 16;
  localparam int A_LOG_LO  = 15;
  localparam int A_SEC_HI  = 14;
  localparam int A_SEC_LO  = 9;
  localparam int A_BYTE_HI = 8;

  // log selectors
  localparam logic [1:0] LOG_ERR = 2'h0;
  localparam logic [1:0] LOG_ST  = 2'h1;
  localparam logic [1:0] LOG_SEL = 2'h2;

  // comprehensive error log geometry
  localparam logic [5:0] ERR_SECTORS   = 6'h02;
  localparam int         ERR_SLOTS     = 10;
  localparam logic [3:0] ERR_LAST_SLOT = 4'h9;
  localparam logic [3:0] ERR_PER_SECT  = 4'h5;
  localparam int         ERR_REC_BYTES = 8;
  localparam logic [8:0] B_ERR_FIRST   = 9'h002;
  localparam logic [8:0] ERR_STRUCT    = 9'h05a;
  localparam logic [8:0] B_ERR_LAST    = 9'h1c3;
  localparam logic [8:0] B_CNT_LO      = 9'h1c4;
  localparam logic [8:0] B_CNT_HI      = 9'h1c5;
  localparam logic [7:0] ERR_VERSION   = 8'h01;
  localparam logic [15:0] CNT_MAX      = 16'hffff;

  // self-test log geometry
  localparam int         ST_SLOTS     = 21;
  localparam logic [4:0] ST_LAST_SLOT = 5'h14;
  localparam int         ST_REC_BYTES = 9;
  localparam logic [8:0] B_ST_FIRST   = 9'h002;
  localparam logic [8:0] ST_DESC      = 9'h018;
  localparam logic [8:0] B_ST_LAST    = 9'h1f9;
  localparam logic [8:0] B_ST_IDX     = 9'h1fc;
  localparam logic [7:0] ST_REV_LO    = 8'h01;
  localparam logic [7:0] ST_REV_HI    = 8'h00;

  // selective self-test log layout
  localparam int         SEL_HOST_BYTES = 82;
  localparam logic [8:0] B_SEL_LAST     = 9'h051;
  localparam logic [8:0] B_LBA_FIRST    = 9'h1ec;
  localparam logic [8:0] B_LBA_LAST     = 9'h1f3;
  localparam logic [8:0] B_SPAN_LO      = 9'h1f4;
  localparam logic [8:0] B_SPAN_HI      = 9'h1f5;
  localparam logic [8:0] B_FLG_LO       = 9'h1f6;
  localparam logic [8:0] B_FLG_HI       = 9'h1f7;
  localparam logic [8:0] B_PEND_LO      = 9'h1fc;
  localparam logic [8:0] B_PEND_HI      = 9'h1fd;
  localparam logic [8:0] B_CHK          = 9'h1ff;
  localparam int         FLAG_SCAN_REQ  = 1;
  localparam int         FLAG_PEND      = 3;
  localparam int         FLAG_ACT       = 4;
  localparam logic [15:0] SPAN_SCAN     = 16'h0006;
  localparam logic [63:0] LBA_BLOCK_MASK = 64'hffff_ffff_ffff_0000;

  // pending timer: one minute in clock cycles
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint MINUTE_S      = 60;
  localparam longint NS_PER_S      = 1000000000;
  localparam longint MINUTE_CYCLES = MINUTE_S * NS_PER_S / CLK_PERIOD_NS;
  localparam int     TMR_W         = 40;

endpackage : sesl_pkg

// >>> testbench/sesl_host.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the log port: one strobe per access, changed after an edge
module sesl_host (
  // clock
  input  wire logic                        clock,
  // log access port
  output logic       [sesl_pkg::ADDR_W-1:0] addr,
  output logic       [7:0]                  wdata,
  output logic                              wr,
  output logic                              rd,
  input  wire logic  [7:0]                  rdata
);
  import sesl_pkg::*;

  // idle bus from time zero
  initial begin
    addr  = '0;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // only the selective log, sector zero, takes writes
  task automatic wr_byte(input logic [1:0] lg, input logic [8:0] b,
                         input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= {lg, 6'h00, b};
    wdata <= d;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_byte

  // read data stands only in the cycle after the strobe
  task automatic rd_byte(input logic [1:0] lg, input logic [5:0] s,
                         input logic [8:0] b, output logic [7:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= {lg, s, b};
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_byte
endmodule : sesl_host

`default_nettype wire

// >>> testbench/test_smart_error_and_selftest_logs.sv
`timescale 1ns/1ps
`default_nettype none

module test_smart_error_and_selftest_logs;
  import sesl_pkg::*;

  logic              clock;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata, rdata, st_sec, st_stat, st_ck;
  logic              wr, rd, err_dev, st_unc, scan_req, scan_resume;
  logic [5:0]        ev;
  logic [63:0]       rec, p_lba, v;
  logic [15:0]       st_hr, p_span, cnt;
  logic [31:0]       st_lba;
  int                seed = 31;
  int                error_cnt = 0;
  int                samples_checked = 0;
  logic [63:0]       errs [0:11];
  logic [63:0]       stx [0:21];
  logic [7:0]        sty [0:21];
  logic [7:0]        sb [0:81];

  // short minute keeps the pending timer inside the run
  sesl_logs #(.MINUTE_CYCLES(20)) u_sesl_logs (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .err_log(ev[0]), .err_dev(err_dev),
    .err_record(rec), .st_log(ev[1]), .st_sector(st_sec),
    .st_status(st_stat), .st_hours(st_hr), .st_checkpoint(st_ck),
    .st_fail_unc(st_unc), .st_fail_lba(st_lba), .sel_prog(ev[2]),
    .sel_prog_lba(p_lba), .sel_prog_span(p_span), .sel_done(ev[3]),
    .scan_suspend(ev[4]), .scan_finish(ev[5]), .scan_req(scan_req),
    .scan_resume(scan_resume));

  sesl_host u_sesl_host (
    .clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  // clock generation
  always #5 clock = ~clock;

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // little-endian field of n bytes
  task automatic rd_field(input logic [1:0] lg, input logic [5:0] s,
                          input logic [8:0] b, input int n,
                          output logic [63:0] f);
    logic [7:0] d;
    f = '0;
    for (int i = 0; i < n; i++) begin
      u_sesl_host.rd_byte(lg, s, b + 9'(i), d);
      f[8*i+:8] = d;
    end
  endtask : rd_field

  task automatic chk_sum(input logic [1:0] lg, input logic [5:0] s);
    logic [7:0] d, sum;
    sum = 8'h00;
    for (int i = 0; i < 512; i++) begin
      u_sesl_host.rd_byte(lg, s, 9'(i), d);
      sum = sum + d;
    end
    check("sector sum", {56'h0, sum}, 64'h0);
  endtask : chk_sum

  // one-cycle event pulse, bit k of ev
  task automatic fire(input int k);
    @(posedge clock);
    ev <= 6'(1 << k);
    @(posedge clock);
    ev <= 6'h00;
  endtask : fire

  function automatic logic [63:0] err_idx(input int n);
    return (n == 0) ? 64'h0 : 64'((n - 1) % ERR_SLOTS + 1);
  endfunction : err_idx

  function automatic logic [63:0] st_idx(input int n);
    return (n == 0) ? 64'h0 : 64'((n - 1) % ST_SLOTS + 1);
  endfunction : st_idx

  task automatic log_err(input int n);
    logic [31:0] a, b;
    a = $random(seed);
    b = $random(seed);
    errs[n] = {a, b};
    if (b[0]) cnt = cnt + 16'h0001;
    @(posedge clock);
    rec     <= {a, b};
    err_dev <= b[0];
    fire(0);
  endtask : log_err

  // descriptor image: lba low 24, checkpoint, hours, status, sector
  task automatic log_st(input int n);
    logic [31:0] a, b, c;
    logic        u;
    a = $random(seed);
    b = $random(seed);
    c = $random(seed);
    u = (n == 21) ? 1'b1 : (n == 1) ? 1'b0 : c[31];
    stx[n] = {u ? b[23:0] : 24'h0, a[23:16], c[15:0], a[15:8], a[7:0]};
    sty[n] = u ? b[31:24] : 8'h00;
    @(posedge clock);
    st_sec  <= a[7:0];
    st_stat <= a[15:8];
    st_hr   <= c[15:0];
    st_ck   <= a[23:16];
    st_unc  <= u;
    st_lba  <= b;
    fire(1);
  endtask : log_st

  task automatic sel_phase;
    logic [31:0] a;
    int          k;
    // host image: revision, spans, span three written as all zero
    for (int i = 0; i < 82; i++) begin
      a = (i == 0) ? 32'h0000_0001 : $random(seed);
      sb[i] = (i == 1 || (i >= 34 && i < 50)) ? 8'h00 : a[7:0];
      u_sesl_host.wr_byte(LOG_SEL, 9'(i), sb[i]);
    end
    for (int i = 492; i < 502; i++) begin
      u_sesl_host.wr_byte(LOG_SEL, 9'(i), 8'h00);
    end
    u_sesl_host.wr_byte(LOG_SEL, B_FLG_LO, 8'h02);
    u_sesl_host.wr_byte(LOG_SEL, B_FLG_HI, 8'h00);
    u_sesl_host.wr_byte(LOG_SEL, B_PEND_LO, 8'hff);
    u_sesl_host.wr_byte(LOG_SEL, B_PEND_HI, 8'hff);
    for (int i = 0; i < 82; i++) begin
      rd_field(LOG_SEL, 0, 9'(i), 1, v);
      check("sel host byte", v, {56'h0, sb[i]});
    end
    check("scan request", {63'h0, scan_req}, 64'h1);
    chk_sum(LOG_SEL, 0);
    // progress update, then completion
    a = $random(seed);
    @(posedge clock);
    p_lba  <= {a, ~a};
    p_span <= 16'h0002;
    fire(2);
    rd_field(LOG_SEL, 0, B_LBA_FIRST, 8, v);
    check("current lba", v, {a, ~a} & 64'hffff_ffff_ffff_0000);
    rd_field(LOG_SEL, 0, B_SPAN_LO, 2, v);
    check("current span", v, 64'h2);
    chk_sum(LOG_SEL, 0);
    fire(3);
    rd_field(LOG_SEL, 0, B_LBA_FIRST, 8, v);
    check("lba after done", v, 64'h0);
    rd_field(LOG_SEL, 0, B_SPAN_LO, 2, v);
    check("span after done", v, 64'h0);
    // scan suspended, pending timer then expires
    fire(4);
    rd_field(LOG_SEL, 0, B_FLG_LO, 2, v);
    check("flags pending", v, 64'h000a);
    u_sesl_host.wr_byte(LOG_SEL, B_PEND_LO, 8'h02);
    u_sesl_host.wr_byte(LOG_SEL, B_PEND_HI, 8'h00);
    k = 0;
    while (scan_resume !== 1'b1 && k < 50) begin
      @(posedge clock);
      #1 k++;
    end
    if (k == 50) begin
      check("scan resume", {63'h0, scan_resume}, 64'h1);
      report_and_stop;
    end
    rd_field(LOG_SEL, 0, B_FLG_LO, 2, v);
    check("flags active", v, 64'h0012);
    rd_field(LOG_SEL, 0, B_SPAN_LO, 2, v);
    check("span in scan", v, 64'h0006);
    chk_sum(LOG_SEL, 0);
    fire(5);
    rd_field(LOG_SEL, 0, B_FLG_LO, 2, v);
    check("flags finished", v, 64'h0002);
  endtask : sel_phase

  // main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    ev = 6'h00;
    err_dev = 1'b0;
    rec = '0;
    {st_sec, st_stat, st_ck, st_hr, st_lba, st_unc} = '0;
    p_lba = '0;
    p_span = 16'h0000;
    cnt = 16'h0000;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd_field(LOG_ERR, 0, 9'h000, 2, v);
    check("err version index", v, 64'h0001);
    rd_field(LOG_ERR, 1, B_ERR_FIRST + ERR_STRUCT * 9'h004, 8, v);
    check("err slot empty", v, 64'h0);
    rd_field(LOG_ST, 0, 9'h000, 2, v);
    check("st revision", v, 64'h0001);
    rd_field(LOG_ST, 0, B_ST_IDX, 1, v);
    check("st index empty", v, 64'h0);
    chk_sum(LOG_ERR, 0);
    chk_sum(LOG_ST, 0);
    for (int n = 0; n < 12; n++) begin
      log_err(n);
      rd_field(LOG_ERR, 0, 9'h001, 1, v);
      check("err index", v, err_idx(n + 1));
    end
    for (int s = 0; s < ERR_SLOTS; s++) begin
      rd_field(LOG_ERR, 6'(s / 5), B_ERR_FIRST + ERR_STRUCT * 9'(s % 5), 8, v);
      check("err slot", v, errs[s < 2 ? s + 10 : s]);
    end
    rd_field(LOG_ERR, 0, B_CNT_LO, 2, v);
    check("err count", v, {48'h0, cnt});
    rd_field(LOG_ERR, 2, B_ERR_FIRST, 1, v);
    check("err sector two", v, 64'h0);
    chk_sum(LOG_ERR, 0);
    chk_sum(LOG_ERR, 1);
    for (int n = 0; n < 22; n++) begin
      log_st(n);
      rd_field(LOG_ST, 0, B_ST_IDX, 1, v);
      check("st index", v, st_idx(n + 1));
      if (n == 2) begin
        rd_field(LOG_ST, 0, B_ST_LAST - 9'h017, 8, v);
        check("st unused slot", v, 64'h0);
      end
    end
    for (int k = 0; k < 3; k++) begin
      int s;
      s = (k == 2) ? 20 : k;
      rd_field(LOG_ST, 0, B_ST_FIRST + ST_DESC * 9'(s), 8, v);
      check("st desc", v, stx[s == 0 ? 21 : s]);
      rd_field(LOG_ST, 0, B_ST_FIRST + ST_DESC * 9'(s) + 9'h008, 1, v);
      check("st lba top", v, {56'h0, sty[s == 0 ? 21 : s]});
    end
    // the self-test log refuses host writes
    u_sesl_host.wr_byte(LOG_ST, B_ST_IDX, 8'h55);
    rd_field(LOG_ST, 0, B_ST_IDX, 1, v);
    check("st index kept", v, st_idx(22));
    chk_sum(LOG_ST, 0);
    sel_phase;
    report_and_stop;
  end
endmodule : test_smart_error_and_selftest_logs

`default_nettype wire
